//--- src/pad_mux_pkg.sv
// Package for the pad function select of seven multiplexed pins.
// Assumes one 100 MHz clock and synchronous configuration inputs.
// Summary of operation
// - Analog select in port A high nibble [3:0] hands pin A4 to converter input 4.
// - Analog select in port A high nibble [7:4] hands pin A5 to converter input 5.
// - Packet-trace frame drives pin A4 when cpu trace is off, packet trace on and alt output selected.
// - Packet-trace data drives pin A5 when cpu trace is off, packet trace on and alt output selected.
// - Four-wire cpu trace puts trace bits 2 and 3 on pins A4 and A5 under alt output select.
// - The low-active boot select on pin A5 is caught at reset release and starts the factory monitor.
// - Serial 3 request-to-send drives pin D4 in UART mode with config bit 5 and alt output selected.
// - Pin D4 is serial 3 slave select input in SPI slave mode.
// - Serial 4 master drives master-out on pin E0 under alt select; as slave it receives.
// - In two-wire mode pin E1 carries serial 4 data open-drain under open-drain alt select.
// - In SPI mode pin E1 drives slave-out as slave and receives master-in as master.
// - Pin A6 outputs timer 1 channel 3 when enabled and alt output selected; input never remapped.
// - Timer 2 option bit 4 routes timer 2 channel 1 to pin B1 when enabled and alt selected.
// - Serial 1 SPI output on pin B1 needs timer 2 output off or remap clear, SPI mode, alt select.
// - In two-wire mode pin B1 carries serial 1 data open-drain when the timer 2 conflict is avoided.
// - In UART mode pin B1 drives serial 1 transmit when alt selected and the timer conflict avoided.
package pad_mux_pkg;
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hD;
  localparam logic [1:0] MODE_UART = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h2;
  localparam logic [1:0] MODE_TWI = 2'h3;
  localparam int NIB0 = 0;
  localparam int NIB1 = 4;
  localparam int NIB2 = 8;
  localparam int SPI_SLAVE_BIT = 4;
  localparam int UART_RTS_BIT = 5;
  localparam int TIM2_REMAP_BIT = 4;
  localparam logic BOOT_RESET_VAL = 1'b0;
  // One serial controller's view of the pad
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] spi_cfg;
    logic [7:0] uart_cfg;
  } ser_cfg_t;
  // Output and output enable of one pad
  typedef struct packed {
    logic o;
    logic oe;
  } pad_drive_t;
endpackage

//--- src/pad_select.sv
// One pad's driver: picks alternate, open-drain or plain digital drive.
// Assumes the select terms are computed by the parent.
`timescale 1ns/1ps
`default_nettype none
module pad_select (
  input wire logic i_alt_en,
  input wire logic i_alt_od,
  input wire logic i_alt_val,
  input wire logic i_gpio_out,
  input wire logic i_gpio_oe,
  output var pad_mux_pkg::pad_drive_t o_drive
);
  always_comb begin
    if (i_alt_od) begin
      // Open drain drives only low
      o_drive.o = 1'b0;
      o_drive.oe = ~i_alt_val;
    end else if (i_alt_en) begin
      o_drive.o = i_alt_val;
      o_drive.oe = 1'b1;
    end else begin
      o_drive.o = i_gpio_out;
      o_drive.oe = i_gpio_oe;
    end
  end
endmodule
`default_nettype wire

//--- src/pad_function_select.sv
// Pad function select for pins A4, A5, A6, B1, D4, E0, E1.
// Assumes all inputs synchronous to I_REF_CLK; outputs registered.
`timescale 1ns/1ps
`default_nettype none
module pad_function_select (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic [15:0] I_PORT_A_HIGH_CONFIG,
  input wire logic [15:0] I_PORT_B_LOW_CONFIG,
  input wire logic [15:0] I_PORT_D_HIGH_CONFIG,
  input wire logic [15:0] I_PORT_E_LOW_CONFIG,
  input wire logic [6:0] I_GPIO_OUT,
  input wire logic [6:0] I_GPIO_OE,
  input wire logic I_CPU_TRACE_EN,
  input wire logic I_CPU_TRACE_4WIRE,
  input wire logic I_PACKET_TRACE_EN,
  input wire logic I_PACKET_TRACE_FRAME,
  input wire logic I_PACKET_TRACE_DATA,
  input wire logic I_CPU_TRACE_BIT_TWO,
  input wire logic I_CPU_TRACE_BIT_THREE,
  input wire pad_mux_pkg::ser_cfg_t I_SER1_CFG,
  input wire pad_mux_pkg::ser_cfg_t I_SER3_CFG,
  input wire pad_mux_pkg::ser_cfg_t I_SER4_CFG,
  input wire logic I_SER1_MASTER_OUT,
  input wire logic I_SER1_MASTER_IN,
  input wire logic I_SER1_TWOWIRE_DATA,
  input wire logic I_SER1_TRANSMIT,
  input wire logic I_SER3_REQUEST_TO_SEND_N,
  input wire logic I_SER4_MASTER_OUT,
  input wire logic I_SER4_MASTER_IN,
  input wire logic I_SER4_TWOWIRE_DATA,
  input wire logic I_TIMER1_CHANNEL3,
  input wire logic I_TIMER1_CAPTURE_ENABLE,
  input wire logic I_TIMER2_CHANNEL1,
  input wire logic I_TIMER2_CAPTURE_ENABLE,
  input wire logic [7:0] I_TIMER2_OPTION_REG,
  // Pad inputs, order A4 A5 A6 B1 D4 E0 E1
  input wire logic [6:0] I_PAD_IN,
  output logic [6:0] O_PAD_OUT,
  output logic [6:0] O_PAD_OE,
  output logic O_CONVERTER_INPUT_FOUR_EN,
  output logic O_CONVERTER_INPUT_FIVE_EN,
  output logic [6:0] O_GPIO_IN,
  output logic O_SER3_SLAVE_SELECT_N,
  output logic O_SER4_DATA_IN,
  output logic O_SER4_TWOWIRE_IN,
  output logic O_SER1_DATA_IN,
  output logic O_TIMER1_CHANNEL3_IN,
  output logic O_FACTORY_MONITOR
);
  localparam int PAD_A4 = 0;
  localparam int PAD_A5 = 1;
  localparam int PAD_A6 = 2;
  localparam int PAD_B1 = 3;
  localparam int PAD_D4 = 4;
  localparam int PAD_E0 = 5;
  localparam int PAD_E1 = 6;

  function automatic logic [3:0] nib(input logic [15:0] c, input int p);
    nib = c[p+:4];
  endfunction

  logic [6:0] alt_en;
  logic [6:0] alt_od;
  logic [6:0] alt_val;
  pad_mux_pkg::pad_drive_t drv [7];
  logic boot_seen_q;
  logic ser1_spi;
  logic ser1_slave;
  logic ser3_spi;
  logic ser4_spi;
  logic ser4_slave;
  logic tim2_b1;
  logic a4_alt;
  logic a5_alt;

  assign ser1_spi = I_SER1_CFG.mode == pad_mux_pkg::MODE_SPI;
  assign ser1_slave = I_SER1_CFG.spi_cfg[pad_mux_pkg::SPI_SLAVE_BIT];
  assign ser3_spi = I_SER3_CFG.mode == pad_mux_pkg::MODE_SPI;
  assign ser4_spi = I_SER4_CFG.mode == pad_mux_pkg::MODE_SPI;
  assign ser4_slave = I_SER4_CFG.spi_cfg[pad_mux_pkg::SPI_SLAVE_BIT];
  assign tim2_b1 = I_TIMER2_CAPTURE_ENABLE &
    I_TIMER2_OPTION_REG[pad_mux_pkg::TIM2_REMAP_BIT];
  assign a4_alt = nib(I_PORT_A_HIGH_CONFIG, pad_mux_pkg::NIB0) ==
    pad_mux_pkg::CFG_ALT_OUT;
  assign a5_alt = nib(I_PORT_A_HIGH_CONFIG, pad_mux_pkg::NIB1) ==
    pad_mux_pkg::CFG_ALT_OUT;

  always_comb begin
    alt_en = 7'h00;
    alt_od = 7'h00;
    alt_val = 7'h00;
    if (a4_alt && !I_CPU_TRACE_EN && I_PACKET_TRACE_EN) begin
      alt_en[PAD_A4] = 1'b1;
      alt_val[PAD_A4] = I_PACKET_TRACE_FRAME;
    end else if (a4_alt && I_CPU_TRACE_EN && I_CPU_TRACE_4WIRE) begin
      alt_en[PAD_A4] = 1'b1;
      alt_val[PAD_A4] = I_CPU_TRACE_BIT_TWO;
    end
    if (a5_alt && !I_CPU_TRACE_EN && I_PACKET_TRACE_EN) begin
      alt_en[PAD_A5] = 1'b1;
      alt_val[PAD_A5] = I_PACKET_TRACE_DATA;
    end else if (a5_alt && I_CPU_TRACE_EN && I_CPU_TRACE_4WIRE) begin
      alt_en[PAD_A5] = 1'b1;
      alt_val[PAD_A5] = I_CPU_TRACE_BIT_THREE;
    end
    if (nib(I_PORT_A_HIGH_CONFIG, pad_mux_pkg::NIB2) ==
        pad_mux_pkg::CFG_ALT_OUT && I_TIMER1_CAPTURE_ENABLE) begin
      alt_en[PAD_A6] = 1'b1;
      alt_val[PAD_A6] = I_TIMER1_CHANNEL3;
    end
    if (nib(I_PORT_D_HIGH_CONFIG, pad_mux_pkg::NIB0) ==
        pad_mux_pkg::CFG_ALT_OUT &&
        I_SER3_CFG.mode == pad_mux_pkg::MODE_UART &&
        I_SER3_CFG.uart_cfg[pad_mux_pkg::UART_RTS_BIT]) begin
      alt_en[PAD_D4] = 1'b1;
      alt_val[PAD_D4] = I_SER3_REQUEST_TO_SEND_N;
    end
    if (nib(I_PORT_E_LOW_CONFIG, pad_mux_pkg::NIB0) ==
        pad_mux_pkg::CFG_ALT_OUT && ser4_spi && !ser4_slave) begin
      alt_en[PAD_E0] = 1'b1;
      alt_val[PAD_E0] = I_SER4_MASTER_OUT;
    end
    if (nib(I_PORT_E_LOW_CONFIG, pad_mux_pkg::NIB1) ==
        pad_mux_pkg::CFG_ALT_OD &&
        I_SER4_CFG.mode == pad_mux_pkg::MODE_TWI) begin
      alt_od[PAD_E1] = 1'b1;
      alt_val[PAD_E1] = I_SER4_TWOWIRE_DATA;
    end else if (nib(I_PORT_E_LOW_CONFIG, pad_mux_pkg::NIB1) ==
        pad_mux_pkg::CFG_ALT_OUT && ser4_spi && ser4_slave) begin
      alt_en[PAD_E1] = 1'b1;
      alt_val[PAD_E1] = I_SER4_MASTER_IN;
    end
    if (nib(I_PORT_B_LOW_CONFIG, pad_mux_pkg::NIB1) ==
        pad_mux_pkg::CFG_ALT_OUT && tim2_b1) begin
      alt_en[PAD_B1] = 1'b1;
      alt_val[PAD_B1] = I_TIMER2_CHANNEL1;
    end else if (nib(I_PORT_B_LOW_CONFIG, pad_mux_pkg::NIB1) ==
        pad_mux_pkg::CFG_ALT_OD && !tim2_b1 &&
        I_SER1_CFG.mode == pad_mux_pkg::MODE_TWI) begin
      alt_od[PAD_B1] = 1'b1;
      alt_val[PAD_B1] = I_SER1_TWOWIRE_DATA;
    end else if (nib(I_PORT_B_LOW_CONFIG, pad_mux_pkg::NIB1) ==
        pad_mux_pkg::CFG_ALT_OUT && !tim2_b1) begin
      if (ser1_spi) begin
        alt_en[PAD_B1] = 1'b1;
        alt_val[PAD_B1] = ser1_slave ? I_SER1_MASTER_IN : I_SER1_MASTER_OUT;
      end else if (I_SER1_CFG.mode == pad_mux_pkg::MODE_UART) begin
        alt_en[PAD_B1] = 1'b1;
        alt_val[PAD_B1] = I_SER1_TRANSMIT;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_pad
      pad_select u_sel (
        .i_alt_en(alt_en[g]),
        .i_alt_od(alt_od[g]),
        .i_alt_val(alt_val[g]),
        .i_gpio_out(I_GPIO_OUT[g]),
        .i_gpio_oe(I_GPIO_OE[g]),
        .o_drive(drv[g])
      );
    end
  endgenerate

  // Pad drive registers; analog pins are released
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_PAD_OUT <= 7'h00;
      O_PAD_OE <= 7'h00;
    end else begin
      for (int i = 0; i < 7; i++) begin
        O_PAD_OUT[i] <= drv[i].o;
        O_PAD_OE[i] <= drv[i].oe;
      end
      if (nib(I_PORT_A_HIGH_CONFIG, pad_mux_pkg::NIB0) ==
          pad_mux_pkg::CFG_ANALOG) begin
        O_PAD_OE[PAD_A4] <= 1'b0;
      end
      if (nib(I_PORT_A_HIGH_CONFIG, pad_mux_pkg::NIB1) ==
          pad_mux_pkg::CFG_ANALOG) begin
        O_PAD_OE[PAD_A5] <= 1'b0;
      end
    end
  end

  // Converter connects
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_CONVERTER_INPUT_FOUR_EN <= 1'b0;
      O_CONVERTER_INPUT_FIVE_EN <= 1'b0;
    end else begin
      O_CONVERTER_INPUT_FOUR_EN <= nib(I_PORT_A_HIGH_CONFIG,
        pad_mux_pkg::NIB0) == pad_mux_pkg::CFG_ANALOG;
      O_CONVERTER_INPUT_FIVE_EN <= nib(I_PORT_A_HIGH_CONFIG,
        pad_mux_pkg::NIB1) == pad_mux_pkg::CFG_ANALOG;
    end
  end

  // Peripheral inputs from the pads
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_GPIO_IN <= 7'h00;
      O_SER3_SLAVE_SELECT_N <= 1'b1;
      O_SER4_DATA_IN <= 1'b0;
      O_SER4_TWOWIRE_IN <= 1'b1;
      O_SER1_DATA_IN <= 1'b0;
      O_TIMER1_CHANNEL3_IN <= 1'b0;
    end else begin
      O_GPIO_IN <= I_PAD_IN;
      O_SER3_SLAVE_SELECT_N <= (ser3_spi &&
        I_SER3_CFG.spi_cfg[pad_mux_pkg::SPI_SLAVE_BIT]) ?
        I_PAD_IN[PAD_D4] : 1'b1;
      O_SER4_DATA_IN <= ser4_slave ? I_PAD_IN[PAD_E0] : I_PAD_IN[PAD_E1];
      O_SER4_TWOWIRE_IN <= I_PAD_IN[PAD_E1];
      O_SER1_DATA_IN <= I_PAD_IN[PAD_B1];
      O_TIMER1_CHANNEL3_IN <= I_PAD_IN[PAD_A6];
    end
  end

  // Boot select caught at reset release
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      boot_seen_q <= 1'b0;
      O_FACTORY_MONITOR <= pad_mux_pkg::BOOT_RESET_VAL;
    end else if (!boot_seen_q) begin
      boot_seen_q <= 1'b1;
      O_FACTORY_MONITOR <= ~I_PAD_IN[PAD_A5];
    end
  end

  a_boot_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    boot_seen_q |=> $stable(O_FACTORY_MONITOR))
    else $error("factory monitor changed after capture");
  a_boot_take: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    !boot_seen_q |=> O_FACTORY_MONITOR == !$past(I_PAD_IN[PAD_A5]))
    else $error("boot select not captured");
  a_conv_four: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    O_CONVERTER_INPUT_FOUR_EN |-> !O_PAD_OE[PAD_A4])
    else $error("pin A4 driven in analog mode");
  a_conv_five: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    O_CONVERTER_INPUT_FIVE_EN |-> !O_PAD_OE[PAD_A5])
    else $error("pin A5 driven in analog mode");
  a_ptrace_frame: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (a4_alt && !I_CPU_TRACE_EN && I_PACKET_TRACE_EN) |=>
    O_PAD_OE[PAD_A4] && O_PAD_OUT[PAD_A4] == $past(I_PACKET_TRACE_FRAME))
    else $error("packet trace frame missing");
  a_ptrace_data: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (a5_alt && !I_CPU_TRACE_EN && I_PACKET_TRACE_EN) |=>
    O_PAD_OE[PAD_A5] && O_PAD_OUT[PAD_A5] == $past(I_PACKET_TRACE_DATA))
    else $error("packet trace data missing");
  a_tim2_block: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (tim2_b1 && nib(I_PORT_B_LOW_CONFIG, pad_mux_pkg::NIB1) ==
    pad_mux_pkg::CFG_ALT_OUT) |=>
    O_PAD_OUT[PAD_B1] == $past(I_TIMER2_CHANNEL1))
    else $error("timer 2 remap not on pin B1");
  a_ser4_od: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    alt_od[PAD_E1] |=> !O_PAD_OUT[PAD_E1])
    else $error("open drain pin driven high");
  a_rts_drive: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    alt_en[PAD_D4] |=> O_PAD_OE[PAD_D4] &&
    O_PAD_OUT[PAD_D4] == $past(I_SER3_REQUEST_TO_SEND_N))
    else $error("request to send not on pin D4");
  a_tim1_drive: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    alt_en[PAD_A6] |=> O_PAD_OE[PAD_A6] &&
    O_PAD_OUT[PAD_A6] == $past(I_TIMER1_CHANNEL3))
    else $error("timer 1 channel 3 not on pin A6");
  a_mosi_four: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    alt_en[PAD_E0] |=> O_PAD_OE[PAD_E0] &&
    O_PAD_OUT[PAD_E0] == $past(I_SER4_MASTER_OUT))
    else $error("serial 4 master out not on pin E0");
  a_ssel_idle: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    !(ser3_spi && I_SER3_CFG.spi_cfg[pad_mux_pkg::SPI_SLAVE_BIT]) |=>
    O_SER3_SLAVE_SELECT_N)
    else $error("slave select active outside slave mode");
  a_tx_one: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
    (!tim2_b1 && !ser1_spi &&
    I_SER1_CFG.mode == pad_mux_pkg::MODE_UART &&
    nib(I_PORT_B_LOW_CONFIG, pad_mux_pkg::NIB1) ==
    pad_mux_pkg::CFG_ALT_OUT) |=> O_PAD_OE[PAD_B1] &&
    O_PAD_OUT[PAD_B1] == $past(I_SER1_TRANSMIT))
    else $error("serial 1 transmit not on pin B1");
endmodule
`default_nettype wire

//--- sim/pad_partner.sv
// Pad model: resolves each pad level from the block and an outside driver.
// Where the block drives a pad, its level wins over the outside driver.
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  input wire logic i_clk,
  input wire logic [6:0] i_out,
  input wire logic [6:0] i_oe,
  input wire logic [6:0] i_ext_val,
  input wire logic [6:0] i_ext_en,
  output logic [6:0] o_level
);
  logic [6:0] float_q = 7'h00;
  // Floating pads toggle so no stale level passes for data
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      if (i_oe[k]) begin
        o_level[k] = i_out[k];
      end else begin
        o_level[k] = i_ext_en[k] ? i_ext_val[k] : float_q[k];
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/test_pad_function_select.sv
// Bench for the pad function select: sets each function, checks the pads.
// Assumes pad_partner resolves pad levels; pad bit 0 is A4, bit 6 is E1.
`timescale 1ns/1ps
`default_nettype none
module test_pad_function_select;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [15:0] ca = 16'h4444, cb = 16'h4444, cd = 16'h4444, ce = 16'h4444;
  logic [6:0] go = 7'h00, ge = 7'h00, xv = 7'h00, xe = 7'h7F;
  logic cte = 1'h0, c4w = 1'h0, pte = 1'h0, ptf = 1'h0, ptd = 1'h0;
  logic tb2 = 1'h0, tb3 = 1'h0, m1o = 1'h0, m1i = 1'h0, w1 = 1'h0;
  logic tx1 = 1'h0, rts = 1'h1, m4o = 1'h0, m4i = 1'h0, w4 = 1'h1;
  logic t1c = 1'h0, t1e = 1'h0, t2c = 1'h0, t2e = 1'h0;
  logic [7:0] t2o = 8'h00;
  pad_mux_pkg::ser_cfg_t s1 = '0, s3 = '0, s4 = '0;
  logic [6:0] pin, pout, poe, gin;
  logic cv4, cv5, ssel, s4in, s4w, s1in, t1in, fmon;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pad_function_select pad_function_select_i (.I_REF_CLK(clk),
    .I_RESETN(rst_n), .I_PORT_A_HIGH_CONFIG(ca), .I_PORT_B_LOW_CONFIG(cb),
    .I_PORT_D_HIGH_CONFIG(cd), .I_PORT_E_LOW_CONFIG(ce), .I_GPIO_OUT(go),
    .I_GPIO_OE(ge), .I_CPU_TRACE_EN(cte), .I_CPU_TRACE_4WIRE(c4w),
    .I_PACKET_TRACE_EN(pte), .I_PACKET_TRACE_FRAME(ptf),
    .I_PACKET_TRACE_DATA(ptd), .I_CPU_TRACE_BIT_TWO(tb2),
    .I_CPU_TRACE_BIT_THREE(tb3), .I_SER1_CFG(s1), .I_SER3_CFG(s3),
    .I_SER4_CFG(s4), .I_SER1_MASTER_OUT(m1o), .I_SER1_MASTER_IN(m1i),
    .I_SER1_TWOWIRE_DATA(w1), .I_SER1_TRANSMIT(tx1),
    .I_SER3_REQUEST_TO_SEND_N(rts), .I_SER4_MASTER_OUT(m4o),
    .I_SER4_MASTER_IN(m4i), .I_SER4_TWOWIRE_DATA(w4),
    .I_TIMER1_CHANNEL3(t1c), .I_TIMER1_CAPTURE_ENABLE(t1e),
    .I_TIMER2_CHANNEL1(t2c), .I_TIMER2_CAPTURE_ENABLE(t2e),
    .I_TIMER2_OPTION_REG(t2o), .I_PAD_IN(pin), .O_PAD_OUT(pout),
    .O_PAD_OE(poe), .O_CONVERTER_INPUT_FOUR_EN(cv4),
    .O_CONVERTER_INPUT_FIVE_EN(cv5), .O_GPIO_IN(gin),
    .O_SER3_SLAVE_SELECT_N(ssel), .O_SER4_DATA_IN(s4in),
    .O_SER4_TWOWIRE_IN(s4w), .O_SER1_DATA_IN(s1in),
    .O_TIMER1_CHANNEL3_IN(t1in), .O_FACTORY_MONITOR(fmon));
  pad_partner pad_partner_i (.i_clk(clk), .i_out(pout), .i_oe(poe),
    .i_ext_val(xv), .i_ext_en(xe), .o_level(pin));
  task automatic close_out;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [6:0] e,
                     input logic [6:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  // Run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    chk("ssel_rst", 7'h01, ssel);
    chk("oe_rst", 7'h00, poe);
    rst_n <= 1'h1;
    settle();
    chk("fmon_low", 7'h01, fmon);
    xv <= 7'h02;
    go <= 7'h55;
    ge <= 7'h0F;
    settle();
    chk("fmon_held", 7'h01, fmon);
    chk("gpio_out", go, pout);
    chk("gpio_oe", ge, poe);
    chk("gpio_in", (go & ge) | (xv & ~ge), gin);
    chk("conv_off", 7'h00, {cv5, cv4});
    ge <= 7'h03;
    ca <= 16'h4400;
    settle();
    chk("conv_both", 7'h03, {cv5, cv4});
    chk("conv_oe", 7'h00, poe[1:0]);
    ca <= 16'h4440;
    settle();
    chk("conv_four", 7'h01, {cv5, cv4});
    ge <= 7'h00;
    ca <= 16'h4499;
    pte <= 1'h1;
    ptf <= 1'h1;
    settle();
    chk("pkt_oe", 7'h03, poe[1:0]);
    chk("pkt_a", 7'h01, pout[1:0]);
    ptf <= 1'h0;
    ptd <= 1'h1;
    settle();
    chk("pkt_b", 7'h02, pout[1:0]);
    pte <= 1'h0;
    cte <= 1'h1;
    c4w <= 1'h1;
    tb2 <= 1'h1;
    settle();
    chk("trc_a", 7'h01, pout[1:0]);
    tb2 <= 1'h0;
    tb3 <= 1'h1;
    settle();
    chk("trc_b", 7'h02, pout[1:0]);
    cte <= 1'h0;
    cd <= 16'h4449;
    s3.mode <= pad_mux_pkg::MODE_UART;
    s3.uart_cfg <= 8'h20;
    rts <= 1'h0;
    settle();
    chk("rts_lo", 7'h01, {pout[4], poe[4]});
    rts <= 1'h1;
    settle();
    chk("rts_hi", 7'h03, {pout[4], poe[4]});
    cd <= 16'h4444;
    s3.mode <= pad_mux_pkg::MODE_SPI;
    s3.spi_cfg <= 8'h10;
    xv[4] <= 1'h0;
    settle();
    chk("ssel_slv", 7'h00, ssel);
    s3.spi_cfg <= 8'h00;
    settle();
    chk("ssel_mst", 7'h01, ssel);
    ce <= 16'h4449;
    s4.mode <= pad_mux_pkg::MODE_SPI;
    m4o <= 1'h1;
    xv[6] <= 1'h0;
    settle();
    chk("mosi4", 7'h03, {pout[5], poe[5]});
    chk("miso4_in", 7'h00, s4in);
    s4.spi_cfg <= 8'h10;
    ce <= 16'h4494;
    xv[5] <= 1'h1;
    settle();
    chk("mosi4_in", 7'h01, s4in);
    chk("miso4", 7'h01, {pout[6], poe[6]});
    s4.mode <= pad_mux_pkg::MODE_TWI;
    ce <= 16'h44D4;
    w4 <= 1'h0;
    settle();
    chk("sda4_lo", 7'h01, {pout[6], poe[6]});
    w4 <= 1'h1;
    settle();
    chk("sda4_hi", 7'h00, {pout[6], poe[6]});
    chk("sda4_in", 7'h00, s4w);
    ca <= 16'h4944;
    t1e <= 1'h1;
    t1c <= 1'h1;
    settle();
    chk("tim1", 7'h03, {pout[2], poe[2]});
    chk("tim1_in", 7'h01, t1in);
    t1c <= 1'h0;
    settle();
    chk("tim1_lo", 7'h01, {pout[2], poe[2]});
    cb <= 16'h4494;
    t2e <= 1'h1;
    t2o <= 8'h10;
    t2c <= 1'h1;
    s1.mode <= pad_mux_pkg::MODE_UART;
    settle();
    chk("tim2", 7'h03, {pout[3], poe[3]});
    t2o <= 8'h00;
    settle();
    chk("txd_unmap", 7'h01, {pout[3], poe[3]});
    t2o <= 8'h10;
    t2e <= 1'h0;
    tx1 <= 1'h1;
    settle();
    chk("txd_toff", 7'h03, {pout[3], poe[3]});
    s1.mode <= pad_mux_pkg::MODE_SPI;
    m1o <= 1'h1;
    settle();
    chk("mosi1", 7'h03, {pout[3], poe[3]});
    chk("ser1_in", 7'h01, s1in);
    s1.spi_cfg <= 8'h10;
    settle();
    chk("miso1", 7'h01, {pout[3], poe[3]});
    s1.mode <= pad_mux_pkg::MODE_TWI;
    cb <= 16'h44D4;
    settle();
    chk("sda1_lo", 7'h01, {pout[3], poe[3]});
    w1 <= 1'h1;
    settle();
    chk("sda1_hi", 7'h00, {pout[3], poe[3]});
    rst_n <= 1'h0;
    settle();
    chk("oe_rst2", 7'h00, poe);
    rst_n <= 1'h1;
    settle();
    chk("fmon_high", 7'h00, fmon);
    close_out();
  end
endmodule
`default_nettype wire
